// [pkg/clock_status_pkg.sv]
// Constants and carrier types for the clock source status monitor.
// Assumes an Avalon-MM master with byte addressing and 32-bit data.
package clock_status_pkg;

  // Register map
  localparam logic [31:0] STATUS_ADDR  = 32'h4002_8018;
  localparam logic [15:0] STATUS_RESET = 16'h0003;

  // Field positions inside the status word
  localparam int unsigned RSVD_TOP_BIT     = 15;
  localparam int unsigned XTAL_LOST_BIT    = 14;
  localparam int unsigned XTAL_READY_BIT   = 13;
  localparam int unsigned XTAL_LIVE_BIT    = 12;
  localparam int unsigned PLL_UNLOCKED_BIT = 2;
  localparam int unsigned PLL_LOCKED_BIT   = 1;
  localparam int unsigned PLL_LIVE_BIT     = 0;

  // Index of each sticky flag in the internal flag vector
  localparam int unsigned FLAG_COUNT        = 4;
  localparam int unsigned FLAG_XTAL_LOST    = 3;
  localparam int unsigned FLAG_XTAL_READY   = 2;
  localparam int unsigned FLAG_PLL_UNLOCKED = 1;
  localparam int unsigned FLAG_PLL_LOCKED   = 0;

  // Avalon-MM response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    BUS_IDLE = 1'b0,
    BUS_ACK  = 1'b1
  } bus_state_t;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [31:0] address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avmm_req_t;

  typedef struct packed {
    logic        waitrequest;
    logic [31:0] readdata;
    logic [1:0]  response;
  } avmm_rsp_t;

  typedef struct packed {
    logic crystalStable;
    logic pllLocked;
    logic pllConfigValid;
  } clk_src_t;

endpackage

// [rtl/clock_source_status_monitor.sv]
// Clock source status monitor: live crystal and PLL state plus four
// sticky event flags, one 16-bit status register on Avalon-MM.
// Assumes source indications are synchronous to mclk.
//
// Summary of operation
// - Reserved bit 15 always reads zero.
// - Crystal stable falling sets crystal-lost flag.
// - Write 1 clears crystal-lost; flag requests interrupt.
// - Crystal stable rising sets crystal-ready flag.
// - Write 1 clears crystal-ready; flag requests interrupt.
// - Bit 12 shows live crystal stable state.
// - PLL lock loss sets unlocked flag, interrupt source.
// - Unlocked flag re-sets only after relock, loss.
// - PLL lock gain sets locked flag, interrupt source.
// - Locked flag re-sets only after loss, relock.
// - Register resets to 0x0003.
// - Live PLL bit is read-only.
// - Live PLL bit needs lock and valid configuration.
`timescale 1ns/1ps

module clock_source_status_monitor
  import clock_status_pkg::*;
(
  input  wire logic      mclk,
  input  wire logic      resetn,
  input  wire avmm_req_t busReq,
  output avmm_rsp_t      busRsp,
  input  wire clk_src_t  clkSrc,
  input  wire logic      irqEnable,
  output logic           irq
);

  // Full 32-bit compare; any other address answers with an error
  function automatic logic isStatusAddr(input logic [31:0] addr);
    isStatusAddr = (addr == STATUS_ADDR);
  endfunction

  localparam logic [FLAG_COUNT-1:0] FLAG_RESET = {
    STATUS_RESET[XTAL_LOST_BIT],
    STATUS_RESET[XTAL_READY_BIT],
    STATUS_RESET[PLL_UNLOCKED_BIT],
    STATUS_RESET[PLL_LOCKED_BIT]
  };

  localparam avmm_rsp_t RSP_IDLE = '{
    waitrequest: 1'b1,
    readdata:    32'h0000_0000,
    response:    RESP_OKAY
  };

  // Source tracking and sticky flags
  logic                  xtalLive_ff;
  logic                  nxt_xtalLive;
  logic                  pllLive_ff;
  logic                  nxt_pllLive;
  logic [FLAG_COUNT-1:0] flags_ff;
  logic [FLAG_COUNT-1:0] nxt_flags;
  logic [FLAG_COUNT-1:0] setVec;
  logic [FLAG_COUNT-1:0] clrVec;
  logic                  irq_ff;
  logic                  nxt_irq;

  // Bus slave
  bus_state_t            state_ff;
  bus_state_t            nxt_state;
  avmm_rsp_t             rsp_ff;
  avmm_rsp_t             nxt_rsp;
  logic                  wrAccept;
  logic [15:0]           statusWord;

  // Writes land only at the edge where waitrequest is seen low
  assign wrAccept = (state_ff == BUS_ACK) && busReq.write && isStatusAddr(busReq.address);

  always_comb begin
    statusWord                   = 16'h0000;
    statusWord[RSVD_TOP_BIT]     = 1'b0;
    statusWord[XTAL_LOST_BIT]    = flags_ff[FLAG_XTAL_LOST];
    statusWord[XTAL_READY_BIT]   = flags_ff[FLAG_XTAL_READY];
    statusWord[XTAL_LIVE_BIT]    = xtalLive_ff;
    statusWord[PLL_UNLOCKED_BIT] = flags_ff[FLAG_PLL_UNLOCKED];
    statusWord[PLL_LOCKED_BIT]   = flags_ff[FLAG_PLL_LOCKED];
    statusWord[PLL_LIVE_BIT]     = pllLive_ff;
  end

  // Source tracking: edges are taken against the previous live value,
  // so a flag can only set again after the opposite transition.
  always_comb begin
    nxt_xtalLive = clkSrc.crystalStable;
    nxt_pllLive  = clkSrc.pllLocked & clkSrc.pllConfigValid;

    setVec                    = '0;
    setVec[FLAG_XTAL_LOST]    = xtalLive_ff & ~nxt_xtalLive;
    setVec[FLAG_XTAL_READY]   = ~xtalLive_ff & nxt_xtalLive;
    setVec[FLAG_PLL_UNLOCKED] = pllLive_ff & ~nxt_pllLive;
    setVec[FLAG_PLL_LOCKED]   = ~pllLive_ff & nxt_pllLive;

    // Write one to clear, per byte lane; bit 0 and bit 12 ignore writes
    clrVec                    = '0;
    clrVec[FLAG_XTAL_LOST]    = wrAccept & busReq.byteenable[1]
                                & busReq.writedata[XTAL_LOST_BIT];
    clrVec[FLAG_XTAL_READY]   = wrAccept & busReq.byteenable[1]
                                & busReq.writedata[XTAL_READY_BIT];
    clrVec[FLAG_PLL_UNLOCKED] = wrAccept & busReq.byteenable[0]
                                & busReq.writedata[PLL_UNLOCKED_BIT];
    clrVec[FLAG_PLL_LOCKED]   = wrAccept & busReq.byteenable[0]
                                & busReq.writedata[PLL_LOCKED_BIT];
  end

  // A set in the same cycle as a clear wins, so no event is lost
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_COUNT; gi++) begin : g_flag
      assign nxt_flags[gi] = setVec[gi] | (flags_ff[gi] & ~clrVec[gi]);
    end
  endgenerate

  // Follows the flag values as they become visible to software
  assign nxt_irq = irqEnable & (|nxt_flags);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      xtalLive_ff <= STATUS_RESET[XTAL_LIVE_BIT];
      pllLive_ff  <= STATUS_RESET[PLL_LIVE_BIT];
      flags_ff    <= FLAG_RESET;
      irq_ff      <= 1'b0;
    end else begin
      xtalLive_ff <= nxt_xtalLive;
      pllLive_ff  <= nxt_pllLive;
      flags_ff    <= nxt_flags;
      irq_ff      <= nxt_irq;
    end
  end

  // Bus slave: one wait state, then a single-cycle answer. Read data
  // is captured when the request is first seen.
  always_comb begin
    nxt_state = state_ff;
    nxt_rsp   = rsp_ff;
    case (state_ff)
      BUS_IDLE: begin
        if (busReq.read || busReq.write) begin
          nxt_state           = BUS_ACK;
          nxt_rsp.waitrequest = 1'b0;
          if (isStatusAddr(busReq.address)) begin
            nxt_rsp.response = RESP_OKAY;
            if (busReq.read) begin
              nxt_rsp.readdata = {16'h0000, statusWord};
            end else begin
              nxt_rsp.readdata = 32'h0000_0000;
            end
          end else begin
            nxt_rsp.response = RESP_SLVERR;
            nxt_rsp.readdata = 32'h0000_0000;
          end
        end
      end
      BUS_ACK: begin
        nxt_state = BUS_IDLE;
        nxt_rsp   = RSP_IDLE;
      end
      default: begin
        nxt_state = BUS_IDLE;
        nxt_rsp   = RSP_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      state_ff <= BUS_IDLE;
      rsp_ff   <= RSP_IDLE;
    end else begin
      state_ff <= nxt_state;
      rsp_ff   <= nxt_rsp;
    end
  end

  assign busRsp = rsp_ff;
  assign irq    = irq_ff;

endmodule

// [tb/clock_source_status_monitor_bench.sv]
// Bench: directed and random traffic for the clock status monitor.
// Assumes the checker is bound from its own file.
`timescale 1ns/1ps
module clock_source_status_monitor_bench;
  import clock_status_pkg::*;
  logic        mclk      = 1'b0;
  logic        resetn    = 1'b0;
  avmm_req_t   busReq    = '0;
  avmm_rsp_t   busRsp;
  clk_src_t    clkSrc    = 3'h3;
  logic        irqEnable = 1'b0;
  logic        irq;
  logic [15:0] st        = 16'h0003;
  logic [31:0] q;
  logic [31:0] wd;
  logic [3:0]  be;
  logic [2:0]  rv;
  logic [1:0]  r;
  int          errors    = 0;
  int          checked   = 0;
  int          cyc       = 0;
  integer      seed      = 32'hC6F33F4D;
  always #2.5 mclk = ~mclk;
  clock_source_status_monitor DUT (.mclk(mclk), .resetn(resetn), .busReq(busReq), .busRsp(busRsp),
    .clkSrc(clkSrc), .irqEnable(irqEnable), .irq(irq));
  task automatic report_and_stop();
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  // Request held until waitrequest is seen low
  // No own limit: only the cycle ceiling above ends a hung wait
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [3:0] e);
    @(posedge mclk);
    busReq <= '{read: !w, write: w, address: a, writedata: d, byteenable: e};
    do begin
      @(posedge mclk);
    end while (busRsp.waitrequest !== 1'b0);
    q = busRsp.readdata;
    r = busRsp.response;
    busReq.read <= 1'b0;
    busReq.write <= 1'b0;
  endtask
  function automatic logic [15:0] nxt(input logic [15:0] s, input logic x, input logic p);
    s[14] |= s[12] & !x;
    s[13] |= !s[12] & x;
    s[2] |= s[0] & !p;
    s[1] |= !s[0] & p;
    s[12] = x;
    s[0] = p;
    return s;
  endfunction
  function automatic logic [15:0] clr(input logic [15:0] s, input logic [31:0] d, input logic [3:0] e);
    return s & ~{1'b0, d[14:13] & {2{e[1]}}, 10'h000, d[2:1] & {2{e[0]}}, 1'b0};
  endfunction
  task automatic rd_chk();
    bus(1'b0, STATUS_ADDR, 32'h0, 4'hF);
    cmp("status", {16'h0000, st}, q);
    cmp("response", {30'h0, RESP_OKAY}, {30'h0, r});
    cmp("irq", {31'h0, irqEnable & |{st[14:13], st[2:1]}}, {31'h0, irq});
  endtask
  // Inputs settle three cycles before the model moves on
  task automatic step(input logic x, input logic p, input logic c, input logic e);
    @(posedge mclk);
    clkSrc <= '{crystalStable: x, pllLocked: p, pllConfigValid: c};
    irqEnable <= e;
    repeat (3) @(posedge mclk);
    st = nxt(st, x, p & c);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    resetn <= 1'b1;
    rd_chk();
    bus(1'b1, STATUS_ADDR, 32'hFFFF_FFFF, 4'hF);
    st = clr(st, 32'hFFFF_FFFF, 4'hF);
    rd_chk();
    step(1'b0, 1'b1, 1'b0, 1'b1);
    rd_chk();
    bus(1'b0, STATUS_ADDR + 32'h4, 32'h0, 4'hF);
    cmp("unmapped data", 32'h0, q);
    cmp("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, r});
    repeat (40) begin
      rv = 3'($random(seed));
      step(rv[0], rv[1], 1'b1, rv[2]);
      wd = $random(seed);
      be = 4'($random(seed));
      bus(1'b1, STATUS_ADDR, wd, be);
      st = clr(st, wd, be);
      rd_chk();
    end
    report_and_stop();
  end
endmodule

// [tb/clock_status_chk.sv]
// Checker for the clock status monitor ports.
// Assumes requests are raised only while the slave is idle.
`timescale 1ns/1ps
module clock_status_chk
  import clock_status_pkg::*;
(
  input wire logic      mclk,
  input wire logic      resetn,
  input wire avmm_req_t busReq,
  input wire avmm_rsp_t busRsp,
  input wire clk_src_t  clkSrc,
  input wire logic      irqEnable,
  input wire logic      irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  wire logic rdAns = busReq.read && !busRsp.waitrequest && busRsp.response == RESP_OKAY;
  rsvd_zero_a: assert property (rdAns |-> busRsp.readdata[31:15] == 17'h0) else $error("bit 15 set");
  lost_irq_a: assert property ($fell(clkSrc.crystalStable) && irqEnable |=> irq) else $error("no lost irq");
  ready_irq_a: assert property ($rose(clkSrc.crystalStable) && irqEnable |=> irq) else $error("no ready irq");
  xtal_live_a: assert property (rdAns |-> busRsp.readdata[12] == $past(clkSrc.crystalStable, 2))
    else $error("crystal live bit wrong");
  unlock_irq_a: assert property ($fell(clkSrc.pllLocked && clkSrc.pllConfigValid) && irqEnable |=> irq)
    else $error("no unlock irq");
  lock_irq_a: assert property ($rose(clkSrc.pllLocked && clkSrc.pllConfigValid) && irqEnable |=> irq)
    else $error("no lock irq");
  pll_live_a: assert property (rdAns |-> busRsp.readdata[0] == $past(clkSrc.pllLocked & clkSrc.pllConfigValid, 2))
    else $error("pll live bit wrong");
  irq_mask_a: assert property (!$past(irqEnable) |-> !irq) else $error("irq while disabled");
endmodule
bind clock_source_status_monitor clock_status_chk chk (.mclk(mclk), .resetn(resetn), .busReq(busReq),
  .busRsp(busRsp), .clkSrc(clkSrc), .irqEnable(irqEnable), .irq(irq));
